// File: inc/pan_map.svh
`ifndef PAN_MAP_SVH
`define PAN_MAP_SVH

// --------------------------------------------------
// register offsets
// --------------------------------------------------
`define PAN_OFS_CTRL      8'h80
`define PAN_OFS_STAT      8'h84
`define PAN_OFS_ADV       8'h90
`define PAN_OFS_LP        8'h94
`define PAN_OFS_EXP       8'h98
`define PAN_OFS_RESULT    8'hC0

// --------------------------------------------------
// field positions
// --------------------------------------------------
`define PAN_CTRL_LOOP     14
`define PAN_CTRL_SPEED    13
`define PAN_CTRL_ANEN     12
`define PAN_CTRL_RESTART  9
`define PAN_CTRL_DUPLEX   8
`define PAN_STAT_ANDONE   5
`define PAN_STAT_RFAULT   4
`define PAN_STAT_LINK     2
`define PAN_RES_LINK      0
`define PAN_RES_SPEED     1
`define PAN_RES_DUPLEX    2
`define PAN_RES_LOOP      3
`define PAN_RES_ANDONE    4
`define PAN_EXP_PDFAULT   4
`define PAN_EXP_LPNP      3
`define PAN_EXP_NP        2
`define PAN_EXP_PAGE      1
`define PAN_EXP_LPAN      0
`define PAN_PAGE_NP       15
`define PAN_PAGE_RF       13
`define PAN_ABIL_LSB      5
`define PAN_ABIL_MSB      8

// --------------------------------------------------
// reset values and fixed words
// --------------------------------------------------
`define PAN_CTRL_RST      16'h2000
`define PAN_CTRL_WMASK    16'h7100
`define PAN_ADV_WMASK     16'hA5E0
`define PAN_ADV_SEL       16'h0001
`define PAN_STAT_CONST    16'h7849
`define PAN_PD_WORD100    16'h0081
`define PAN_PD_WORD10     16'h0021
`define PAN_PD_ABIL100    4'h4
`define PAN_PD_ABIL10     4'h1

// --------------------------------------------------
// timing
// --------------------------------------------------
`define PAN_CLK_MHZ        100
`define PAN_BREAK_LINK_MS  1500
`define PAN_BREAK_LINK_CYC (`PAN_BREAK_LINK_MS * 1000 * `PAN_CLK_MHZ)
`define PAN_BURST_GAP_CYC  1600000
`define PAN_TIMER_W        28
`define PAN_GAP_W          21

`endif

// File: inc/pan_pkg.sv
`include "pan_map.svh"

package pan_pkg;

  typedef enum logic [4:0] {
    ST_DISABLED = 5'h01,
    ST_BREAK    = 5'h02,
    ST_ABILITY  = 5'h04,
    ST_NEXTPG   = 5'h08,
    ST_DONE     = 5'h10
  } pan_st_t;

  typedef struct packed {
    pan_st_t                  st;
    logic [15:0]              ctrl;
    logic [15:0]              adv;
    logic [15:0]              lp;
    logic [3:0]               baseAb;
    logic                     baseRf;
    logic                     anArmed;
    logic                     pdFault;
    logic                     pageRcvd;
    logic                     lpAnAble;
    logic                     lpNpAble;
    logic                     speed100;
    logic                     fullDuplex;
    logic                     linkUp;
    logic                     txHalt;
    logic [`PAN_TIMER_W-1:0]  timer;
    logic [15:0]              rdData;
  } pan_state_t;

  typedef struct packed {
    logic [`PAN_GAP_W-1:0]    cnt;
    logic                     burst;
    logic [15:0]              word;
  } pan_flp_t;

endpackage : pan_pkg

// File: hdl/pan_resolve.sv
`timescale 1ns/1ps
`include "pan_map.svh"

// ability nibble order: [0]=10 half, [1]=10 full, [2]=100 half, [3]=100 full
module pan_resolve (
  input  wire logic [3:0] localAb,
  input  wire logic [3:0] partnerAb,
  output logic            found,
  output logic            spd100,
  output logic            fdx
);

  logic [3:0] common;

  always_comb begin
    common = localAb & partnerAb;
    found  = |common;
    spd100 = 1'b0;
    fdx    = 1'b0;
    if (common[3]) begin
      spd100 = 1'b1;
      fdx    = 1'b1;
    end else if (common[2]) begin
      spd100 = 1'b1;
    end else if (common[1]) begin
      fdx    = 1'b1;
    end
  end

endmodule : pan_resolve

// File: hdl/pan_flp_tx.sv
`timescale 1ns/1ps
`include "pan_map.svh"

module pan_flp_tx #(
  parameter int GAP_CYC = `PAN_BURST_GAP_CYC
) (
  input  wire logic        clk,
  input  wire logic        ce,
  input  wire logic        sys_rst,
  input  wire logic        sendEn,
  input  wire logic [15:0] advWord,
  output logic             flpBurst,
  output logic [15:0]      flpWord
);

  pan_pkg::pan_flp_t q_r;
  pan_pkg::pan_flp_t q_nxt;

  // first burst goes out one cycle after enabling, then one per gap
  always_comb begin
    q_nxt       = q_r;
    q_nxt.burst = 1'b0;
    if (!sendEn) begin
      q_nxt.cnt = '0;
    end else if (q_r.cnt == '0) begin
      q_nxt.burst = 1'b1;
      q_nxt.word  = advWord;
      q_nxt.cnt   = `PAN_GAP_W'(GAP_CYC - 1);
    end else begin
      q_nxt.cnt = q_r.cnt - `PAN_GAP_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q_r <= '0;
    end else if (ce) begin
      q_r <= q_nxt;
    end
  end

  assign flpBurst = q_r.burst;
  assign flpWord  = q_r.word;

endmodule : pan_flp_tx

// File: hdl/pan_autoneg.sv
`timescale 1ns/1ps
`include "pan_map.svh"

module pan_autoneg #(
  parameter int BREAK_CYC = `PAN_BREAK_LINK_CYC,
  parameter int GAP_CYC   = `PAN_BURST_GAP_CYC
) (
  input  wire logic        clk,
  input  wire logic        ce,
  input  wire logic        sys_rst,
  input  wire logic        strapAnEnable,
  input  wire logic [3:0]  strapAdvAbility,
  input  wire logic [7:0]  regAddr,
  input  wire logic        regWrEn,
  input  wire logic [15:0] regWrData,
  input  wire logic        regRdEn,
  output logic      [15:0] regRdData,
  input  wire logic        rxPageValid,
  input  wire logic [15:0] rxPageWord,
  input  wire logic        link100Good,
  input  wire logic        link10Good,
  output logic             flpBurst,
  output logic      [15:0] flpWord,
  output logic             txHalt,
  output logic             linkUp,
  output logic             speed100,
  output logic             fullDuplex
);

  // --------------------------------------------------
  // state and helpers
  // --------------------------------------------------
  pan_pkg::pan_state_t q_r;
  pan_pkg::pan_state_t q_nxt;

  logic       anEff;
  logic       found;
  logic       resSpd;
  logic       resFdx;
  logic       resLinkGood;
  logic       resultValid;
  logic       pdSingle;
  logic [15:0] pdWord;
  logic [3:0]  pdAb;

  assign anEff       = q_r.ctrl[`PAN_CTRL_ANEN] & q_r.anArmed;
  assign resLinkGood = resSpd ? link100Good : link10Good;
  assign resultValid = !anEff || (q_r.st == pan_pkg::ST_DONE);
  assign pdSingle    = link100Good ^ link10Good;
  assign pdWord      = link100Good ? `PAN_PD_WORD100 : `PAN_PD_WORD10;
  assign pdAb        = link100Good ? `PAN_PD_ABIL100 : `PAN_PD_ABIL10;

  pan_resolve u_resolve (
    .localAb   (q_r.adv[`PAN_ABIL_MSB:`PAN_ABIL_LSB]),
    .partnerAb (q_r.baseAb),
    .found     (found),
    .spd100    (resSpd),
    .fdx       (resFdx)
  );

  pan_flp_tx #(
    .GAP_CYC (GAP_CYC)
  ) u_flp (
    .clk      (clk),
    .ce       (ce),
    .sys_rst  (sys_rst),
    .sendEn   (q_r.st == pan_pkg::ST_ABILITY || q_r.st == pan_pkg::ST_NEXTPG),
    .advWord  (q_r.adv),
    .flpBurst (flpBurst),
    .flpWord  (flpWord)
  );

  // --------------------------------------------------
  // next state
  // --------------------------------------------------
  always_comb begin
    q_nxt = q_r;

    // register writes
    if (regWrEn && regAddr == `PAN_OFS_CTRL) begin
      q_nxt.ctrl = regWrData & `PAN_CTRL_WMASK;
      if (!regWrData[`PAN_CTRL_ANEN]) begin
        q_nxt.anArmed = 1'b1;
      end
    end
    if (regWrEn && regAddr == `PAN_OFS_ADV) begin
      q_nxt.adv = (regWrData & `PAN_ADV_WMASK) | `PAN_ADV_SEL;
    end

    // register reads; clears happen before hardware sets so a set wins
    if (regRdEn) begin
      case (regAddr)
        `PAN_OFS_CTRL: begin
          q_nxt.rdData = q_r.ctrl;
        end
        `PAN_OFS_STAT: begin
          q_nxt.rdData = `PAN_STAT_CONST;
          q_nxt.rdData[`PAN_STAT_ANDONE] = (q_r.st == pan_pkg::ST_DONE);
          q_nxt.rdData[`PAN_STAT_RFAULT] = q_r.baseRf;
          q_nxt.rdData[`PAN_STAT_LINK]   = q_r.linkUp;
        end
        `PAN_OFS_ADV: begin
          q_nxt.rdData = q_r.adv;
        end
        `PAN_OFS_LP: begin
          q_nxt.rdData = q_r.lp;
        end
        `PAN_OFS_EXP: begin
          q_nxt.rdData = 16'h0000;
          q_nxt.rdData[`PAN_EXP_PDFAULT] = q_r.pdFault;
          q_nxt.rdData[`PAN_EXP_LPNP]    = q_r.lpNpAble;
          q_nxt.rdData[`PAN_EXP_NP]      = 1'b1;
          q_nxt.rdData[`PAN_EXP_PAGE]    = q_r.pageRcvd;
          q_nxt.rdData[`PAN_EXP_LPAN]    = q_r.lpAnAble;
          q_nxt.pageRcvd = 1'b0;
          q_nxt.pdFault  = 1'b0;
        end
        `PAN_OFS_RESULT: begin
          q_nxt.rdData = 16'h0000;
          q_nxt.rdData[`PAN_RES_LINK]   = q_r.linkUp;
          q_nxt.rdData[`PAN_RES_SPEED]  = q_r.speed100 & resultValid;
          q_nxt.rdData[`PAN_RES_DUPLEX] = q_r.fullDuplex & resultValid;
          q_nxt.rdData[`PAN_RES_LOOP]   = q_r.ctrl[`PAN_CTRL_LOOP];
          q_nxt.rdData[`PAN_RES_ANDONE] = (q_r.st == pan_pkg::ST_DONE);
        end
        default: begin
          q_nxt.rdData = 16'h0000;
        end
      endcase
    end

    // --------------------------------------------------
    // negotiation sequence
    // --------------------------------------------------
    case (q_r.st)
      pan_pkg::ST_DISABLED: begin
        q_nxt.speed100   = q_r.ctrl[`PAN_CTRL_SPEED];
        q_nxt.fullDuplex = q_r.ctrl[`PAN_CTRL_DUPLEX];
        q_nxt.linkUp     = q_r.ctrl[`PAN_CTRL_SPEED] ? link100Good : link10Good;
        if (anEff) begin
          q_nxt.st       = pan_pkg::ST_ABILITY;
          q_nxt.linkUp   = 1'b0;
          q_nxt.lpAnAble = 1'b0;
        end
      end
      pan_pkg::ST_BREAK: begin
        // silence on the wire forces the partner into link fail
        if (q_r.timer == '0) begin
          q_nxt.st = pan_pkg::ST_ABILITY;
        end else begin
          q_nxt.timer = q_r.timer - `PAN_TIMER_W'(1);
        end
      end
      pan_pkg::ST_ABILITY: begin
        if (rxPageValid) begin
          q_nxt.lp       = rxPageWord;
          q_nxt.baseAb   = rxPageWord[`PAN_ABIL_MSB:`PAN_ABIL_LSB];
          q_nxt.baseRf   = rxPageWord[`PAN_PAGE_RF];
          q_nxt.lpNpAble = rxPageWord[`PAN_PAGE_NP];
          q_nxt.lpAnAble = 1'b1;
          q_nxt.pageRcvd = 1'b1;
          if (rxPageWord[`PAN_PAGE_NP]) begin
            q_nxt.st = pan_pkg::ST_NEXTPG;
          end
        end else if (q_r.lpAnAble) begin
          if (found && resLinkGood) begin
            q_nxt.st         = pan_pkg::ST_DONE;
            q_nxt.speed100   = resSpd;
            q_nxt.fullDuplex = resFdx;
            q_nxt.linkUp     = 1'b1;
          end
        end else if (pdSingle) begin
          // second pass confirms the word already latched
          q_nxt.lp     = pdWord;
          q_nxt.baseAb = pdAb;
          if (q_r.lp == pdWord && found && resLinkGood) begin
            q_nxt.st         = pan_pkg::ST_DONE;
            q_nxt.speed100   = resSpd;
            q_nxt.fullDuplex = resFdx;
            q_nxt.linkUp     = 1'b1;
          end
        end else if (link100Good && link10Good) begin
          q_nxt.pdFault = 1'b1;
        end
      end
      pan_pkg::ST_NEXTPG: begin
        if (rxPageValid) begin
          q_nxt.lp       = rxPageWord;
          q_nxt.pageRcvd = 1'b1;
          if (!rxPageWord[`PAN_PAGE_NP]) begin
            q_nxt.st = pan_pkg::ST_ABILITY;
          end
        end
      end
      pan_pkg::ST_DONE: begin
        if (!resLinkGood) begin
          q_nxt.st       = pan_pkg::ST_ABILITY;
          q_nxt.linkUp   = 1'b0;
          q_nxt.lpAnAble = 1'b0;
        end
      end
      default: begin
        q_nxt.st = pan_pkg::ST_DISABLED;
      end
    endcase

    // restart outranks the sequence; disable outranks both
    if (regWrEn && regAddr == `PAN_OFS_CTRL && regWrData[`PAN_CTRL_RESTART] && anEff
        && q_r.st != pan_pkg::ST_DISABLED) begin
      q_nxt.st       = pan_pkg::ST_BREAK;
      q_nxt.timer    = `PAN_TIMER_W'(BREAK_CYC - 1);
      q_nxt.linkUp   = 1'b0;
      q_nxt.lpAnAble = 1'b0;
    end
    if (!anEff && q_r.st != pan_pkg::ST_DISABLED) begin
      q_nxt.st     = pan_pkg::ST_DISABLED;
      q_nxt.linkUp = 1'b0;
    end
    q_nxt.txHalt = (q_nxt.st == pan_pkg::ST_BREAK);
  end

  // --------------------------------------------------
  // state register; straps caught in the synchronous reset
  // --------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q_r         <= '0;
      q_r.ctrl    <= `PAN_CTRL_RST | (16'(strapAnEnable) << `PAN_CTRL_ANEN);
      q_r.adv     <= `PAN_ADV_SEL | (16'(strapAdvAbility) << `PAN_ABIL_LSB);
      q_r.anArmed <= strapAnEnable;
      q_r.st      <= strapAnEnable ? pan_pkg::ST_ABILITY : pan_pkg::ST_DISABLED;
    end else if (ce) begin
      q_r <= q_nxt;
    end
  end

  assign regRdData  = q_r.rdData;
  assign txHalt     = q_r.txHalt;
  assign linkUp     = q_r.linkUp;
  assign speed100   = q_r.speed100;
  assign fullDuplex = q_r.fullDuplex;

  // --------------------------------------------------
  // assertions
  // --------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_prio_best: assert property (
    q_r.st == pan_pkg::ST_DONE && q_r.adv[8] && q_r.baseAb[3] |-> speed100 && fullDuplex)
    else $error("best shared mode not chosen");

  a_burst_adv: assert property (
    flpBurst |-> $past(q_r.st) inside {pan_pkg::ST_ABILITY, pan_pkg::ST_NEXTPG}
                 && flpWord == $past(q_r.adv))
    else $error("burst outside negotiation or wrong word");

  a_result_gate: assert property (
    ce && regRdEn && regAddr == `PAN_OFS_RESULT && anEff && q_r.st != pan_pkg::ST_DONE
    |=> regRdData[2:1] == 2'b00)
    else $error("result bits shown before completion");

  a_forced_mode: assert property (
    ce && q_r.st == pan_pkg::ST_DISABLED && !anEff
    |=> speed100 == $past(q_r.ctrl[13]) && fullDuplex == $past(q_r.ctrl[8]))
    else $error("forced speed or duplex not applied");

  a_stat_const: assert property (
    ce && regRdEn && regAddr == `PAN_OFS_STAT
    |=> regRdData[15:11] == 5'h0F && regRdData[3] && regRdData[0] && regRdData[6])
    else $error("basic status constants wrong");

  a_pd_word: assert property (
    ce && q_r.st == pan_pkg::ST_ABILITY && !rxPageValid && !q_r.lpAnAble && link100Good
    && !link10Good |=> q_r.lp == 16'h0081)
    else $error("parallel detect word not loaded");

  a_exp_np: assert property (
    ce && regRdEn && regAddr == `PAN_OFS_EXP |=> regRdData[2] && regRdData[15:5] == '0)
    else $error("expansion next page bit wrong");

  a_link_loss: assert property (
    ce && q_r.st == pan_pkg::ST_DONE && anEff && !resLinkGood && !regWrEn
    |=> q_r.st == pan_pkg::ST_ABILITY && !linkUp)
    else $error("link loss did not resume negotiation");

  a_restart_brk: assert property (
    ce && q_r.st == pan_pkg::ST_DONE && anEff && regWrEn && regAddr == `PAN_OFS_CTRL
    && regWrData[9] && regWrData[12] |=> txHalt ##1 (txHalt || !ce))
    else $error("restart did not break the link");

  a_unarmed_off: assert property (
    !q_r.anArmed |-> q_r.st == pan_pkg::ST_DISABLED && !flpBurst)
    else $error("negotiation ran before being armed");

  // judged on entry: a later advertisement write may narrow the shared set while done
  a_common_done: assert property (
    ce && q_r.st != pan_pkg::ST_DONE && q_nxt.st == pan_pkg::ST_DONE
    |-> found && resLinkGood && q_nxt.linkUp)
    else $error("completion without a shared mode");

  c_done_pages: cover property (
    q_r.st == pan_pkg::ST_NEXTPG ##[1:20] q_r.st == pan_pkg::ST_DONE);
  c_done_pd: cover property (
    q_r.st == pan_pkg::ST_DONE && !q_r.lpAnAble);
  c_break_run: cover property (
    txHalt ##1 q_r.st == pan_pkg::ST_ABILITY);
  c_pd_fault: cover property (
    q_r.pdFault);

endmodule : pan_autoneg

// File: tb/pan_partner.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// far-end station: answers a heard burst with one code word
// ------------------------------------------------------------
module pan_partner (
  input  wire logic        clk,
  input  wire logic        sendReq,
  input  wire logic [15:0] sendWord,
  input  wire logic [3:0]  replyDelay,
  input  wire logic [1:0]  linkSel,
  input  wire logic        flpBurst,
  output logic             rxPageValid,
  output logic      [15:0] rxPageWord,
  output logic             link100Good,
  output logic             link10Good
);
  logic pending;
  int   waitCnt;

  initial begin
    pending     = 1'b0;
    waitCnt     = -1;
    rxPageValid = 1'b0;
    rxPageWord  = 16'h0000;
    link100Good = 1'b0;
    link10Good  = 1'b0;
  end

  always @(posedge clk) begin
    link10Good  <= linkSel[0];
    link100Good <= linkSel[1];
    rxPageValid <= 1'b0;
    // word is not held outside its strobe, so stale data cannot pass
    rxPageWord  <= ~rxPageWord;
    if (sendReq) begin
      pending <= 1'b1;
      waitCnt <= -1;
    end else if (pending && waitCnt < 0 && flpBurst) begin
      waitCnt <= int'(replyDelay);
    end else if (pending && waitCnt == 0) begin
      rxPageValid <= 1'b1;
      rxPageWord  <= sendWord;
      pending     <= 1'b0;
      waitCnt     <= -1;
    end else if (pending && waitCnt > 0) begin
      waitCnt <= waitCnt - 1;
    end
  end
endmodule : pan_partner

// File: tb/pan_autoneg_test.sv
`timescale 1ns/1ps
`include "pan_map.svh"

module pan_autoneg_test;
  // ----------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------
  logic        clk             = 1'b0;
  logic        ce              = 1'b1;
  logic        sys_rst         = 1'b1;
  logic        strapAnEnable   = 1'b1;
  logic [3:0]  strapAdvAbility = 4'hF;
  logic [7:0]  regAddr         = 8'h00;
  logic        regWrEn         = 1'b0;
  logic [15:0] regWrData       = 16'h0000;
  logic        regRdEn         = 1'b0;
  logic        sendReq         = 1'b0;
  logic [15:0] sendWord        = 16'h0000;
  logic [3:0]  replyDelay      = 4'h0;
  logic [1:0]  linkSel         = 2'h0;
  logic [15:0] regRdData, rxPageWord, flpWord;
  logic        rxPageValid, link100Good, link10Good, flpBurst;
  logic        txHalt, linkUp, speed100, fullDuplex;
  int          fails           = 0;
  int          numChecks       = 0;

  always #5 clk = ~clk;

  // short timers keep the run small
  pan_autoneg #(.BREAK_CYC(20), .GAP_CYC(8)) DUT (
    .clk(clk), .ce(ce), .sys_rst(sys_rst), .strapAnEnable(strapAnEnable),
    .strapAdvAbility(strapAdvAbility), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
    .rxPageValid(rxPageValid), .rxPageWord(rxPageWord), .link100Good(link100Good),
    .link10Good(link10Good), .flpBurst(flpBurst), .flpWord(flpWord), .txHalt(txHalt),
    .linkUp(linkUp), .speed100(speed100), .fullDuplex(fullDuplex));

  pan_partner PARTNER (
    .clk(clk), .sendReq(sendReq), .sendWord(sendWord), .replyDelay(replyDelay),
    .linkSel(linkSel), .flpBurst(flpBurst), .rxPageValid(rxPageValid),
    .rxPageWord(rxPageWord), .link100Good(link100Good), .link10Good(link10Good));

  // ----------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", numChecks, fails);
    if (fails == 0 && numChecks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
    numChecks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask : check

  function automatic logic [15:0] mode();
    return {13'h0, linkUp, speed100, fullDuplex};
  endfunction : mode

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr   <= a;
    regWrData <= d;
    regWrEn   <= 1'b1;
    @(posedge clk);
    regWrEn <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m,
                    input string nm);
    @(posedge clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk);
    regRdEn <= 1'b0;
    #1 check(nm, e & m, regRdData & m);
  endtask : rd

  task automatic send(input logic [15:0] w, input logic [3:0] dly);
    @(posedge clk);
    sendWord   <= w;
    replyDelay <= dly;
    sendReq    <= 1'b1;
    @(posedge clk);
    sendReq <= 1'b0;
  endtask : send

  task automatic waitUp(input int lim);
    int n;
    n = 0;
    while (linkUp !== 1'b1 && n < lim) begin
      @(posedge clk);
      #1 n++;
    end
  endtask : waitUp

  task automatic waitBurst(input int lim);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (flpBurst !== 1'b1 && n < lim);
  endtask : waitBurst

  task automatic doReset(input logic en, input logic [3:0] ab);
    @(posedge clk);
    strapAnEnable   <= en;
    strapAdvAbility <= ab;
    sys_rst         <= 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
  endtask : doReset

  // restart with forced bits cleared, far end answers one base word
  task automatic negotiate(input logic [15:0] page, input logic [15:0] adv, input logic up,
                           input logic spd, input logic fdx, input logic [3:0] dly);
    logic [15:0] res;
    res = up ? {11'h0, 1'b1, 1'b0, fdx, spd, 1'b1} : 16'h0000;
    wr(`PAN_OFS_CTRL, 16'h1200);
    #1 check("halt", 16'h0001, {15'h0, txHalt});
    send(page, dly);
    waitBurst(60);
    check("burst word", adv, flpWord);
    if (up) waitUp(200);
    else repeat (60) @(posedge clk);
    #1 check("mode", {13'h0, up, spd, fdx}, mode() & (up ? 16'h7 : 16'h4));
    rd(`PAN_OFS_LP, page, 16'hFFFF, "partner word");
    rd(`PAN_OFS_RESULT, res, 16'hFFFF, "result");
  endtask : negotiate

  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  task automatic t_reset_values();
    waitBurst(10);
    check("first burst", 16'h0001, {15'h0, flpBurst});
    rd(`PAN_OFS_CTRL, 16'h3000, 16'hFFFF, "control");
    rd(`PAN_OFS_ADV, 16'h01E1, 16'hFFFF, "advertisement");
    wr(`PAN_OFS_STAT, 16'hFFFF);
    rd(`PAN_OFS_STAT, 16'h7849, 16'hFFFF, "basic status");
    rd(`PAN_OFS_EXP, 16'h0004, 16'hFFFF, "expansion");
    rd(`PAN_OFS_RESULT, 16'h0000, 16'hFFFF, "result");
    rd(8'h44, 16'h0000, 16'hFFFF, "unmapped");
  endtask : t_reset_values

  task automatic t_priority();
    linkSel <= 2'h3;
    negotiate(16'h01E1, 16'h01E1, 1'b1, 1'b1, 1'b1, 4'h0);
    rd(`PAN_OFS_EXP, 16'h0017, 16'hFFFF, "expansion");
    rd(`PAN_OFS_EXP, 16'h0005, 16'hFFEF, "expansion again");
    rd(`PAN_OFS_STAT, 16'h786D, 16'hFFFF, "basic status");
    negotiate(16'h00E1, 16'h01E1, 1'b1, 1'b1, 1'b0, 4'h5);
    negotiate(16'h0061, 16'h01E1, 1'b1, 1'b0, 1'b1, 4'h0);
    negotiate(16'h0021, 16'h01E1, 1'b1, 1'b0, 1'b0, 4'h5);
  endtask : t_priority

  task automatic t_no_shared();
    wr(`PAN_OFS_ADV, 16'hFFFF);
    rd(`PAN_OFS_ADV, 16'hA5E1, 16'hFFFF, "advertisement mask");
    wr(`PAN_OFS_ADV, 16'h0100);
    negotiate(16'h0021, 16'h0101, 1'b0, 1'b0, 1'b0, 4'h0);
    wr(`PAN_OFS_ADV, 16'h01E1);
  endtask : t_no_shared

  task automatic t_next_page();
    wr(`PAN_OFS_CTRL, 16'h1200);
    send(16'hA1E1, 4'h2);
    waitBurst(60);
    repeat (12) @(posedge clk);
    rd(`PAN_OFS_LP, 16'hA1E1, 16'hFFFF, "base word");
    send(16'h0001, 4'h2);
    waitUp(200);
    #1 check("next page mode", 16'h0007, mode());
    rd(`PAN_OFS_LP, 16'h0001, 16'hFFFF, "next word");
    rd(`PAN_OFS_EXP, 16'h000F, 16'hFFEF, "expansion");
    rd(`PAN_OFS_STAT, 16'h787D, 16'hFFFF, "basic status");
  endtask : t_next_page

  task automatic t_forced();
    wr(`PAN_OFS_CTRL, 16'h2100);
    repeat (3) @(posedge clk);
    #1 check("forced fast full", 16'h0007, mode());
    rd(`PAN_OFS_RESULT, 16'h0007, 16'h0007, "forced result");
    wr(`PAN_OFS_CTRL, 16'h0000);
    repeat (3) @(posedge clk);
    #1 check("forced slow half", 16'h0004, mode());
  endtask : t_forced

  task automatic t_parallel();
    wr(`PAN_OFS_CTRL, 16'h1000);
    for (int i = 0; i < 2; i++) begin
      linkSel <= (i == 1) ? 2'h2 : 2'h1;
      wr(`PAN_OFS_CTRL, 16'h1200);
      repeat (2) @(posedge clk);
      waitUp(200);
      #1 check("detect mode", {13'h0, 1'b1, i[0], 1'b0}, mode());
      rd(`PAN_OFS_LP, (i == 1) ? 16'h0081 : 16'h0021, 16'hFFFF, "detect word");
      rd(`PAN_OFS_EXP, 16'h0004, 16'h0005, "detect able");
    end
    linkSel <= 2'h0;
    repeat (3) @(posedge clk);
    #1 check("link lost", 16'h0000, {15'h0, linkUp});
    linkSel <= 2'h2;
    waitUp(200);
    check("link again", 16'h0001, {15'h0, linkUp});
  endtask : t_parallel

  task automatic t_strap_forced();
    doReset(1'b0, 4'h5);
    rd(`PAN_OFS_CTRL, 16'h2000, 16'hFFFF, "control");
    rd(`PAN_OFS_ADV, 16'h00A1, 16'hFFFF, "advertisement");
    wr(`PAN_OFS_CTRL, 16'h1000);
    waitBurst(40);
    check("unarmed burst", 16'h0000, {15'h0, flpBurst});
    wr(`PAN_OFS_CTRL, 16'h0000);
    wr(`PAN_OFS_CTRL, 16'h1000);
    waitBurst(60);
    check("armed burst", 16'h0001, {15'h0, flpBurst});
    check("armed word", 16'h00A1, flpWord);
  endtask : t_strap_forced

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    wrap_up();
  end

  initial begin
    doReset(1'b1, 4'hF);
    t_reset_values();
    t_priority();
    t_no_shared();
    t_next_page();
    t_forced();
    t_parallel();
    t_strap_forced();
    wrap_up();
  end
endmodule : pan_autoneg_test
